//--- hw/wkevt_ctrl.sv
`timescale 1ns/1ps
// Function
// [RQ1] Two-bit wake cause status at bits 5-4
// [RQ2] Writing one clears cause bit, zero keeps
// [RQ3] Cause clears only when ready in full power
// [RQ4] Cause clears only once its source cleared
// [RQ5] Pulse mode: output active 50 ms per event
// [RQ6] Static mode: output held until deactivated
// [RQ7] Cause clear or enable clear deactivates output
// [RQ8] Polarity bit 2 selects output active level
// [RQ9] Open-drain ignores polarity, active low
// [RQ10] Enable bit 1 gates the external pin
// [RQ11] Interrupt independent of output enable
// [RQ12] Ready bit 0 set only when accessible
// [RQ13] Control register readable in every power state
// [RQ14] Host polls ready after power-up and wake
// [RQ15] Host limited to two registers while unready
// [RQ16] Config register reads permitted while unready
// [RQ17] Power state encodings, 11b reserved
// [RQ18] Byte-test write wakes reduced-power device
// [RQ19] Enabled source raises interrupt regardless
// [RQ20] Ready drops in low power, returns settled
module wkevt_ctrl #(
  parameter int PULSE_LEN = wkevt_pkg::PULSE_CYCLES,
  parameter int SETTLE_LEN = wkevt_pkg::SETTLE_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Host register port
  input wkevt_pkg::wkevt_req_t host_req,
  output logic [31:0] host_rdata,
  output logic host_access_ok,
  // Power state and wake sources
  input wire logic [1:0] power_state_select,
  input wkevt_pkg::wkevt_src_t wake_src,
  input wire logic wake_output_buffer_type,
  // Outputs
  output logic wake_request,
  output logic wake_interrupt,
  output logic ready,
  output logic wake_event_output,
  output logic wake_event_oe
);
  wkevt_pkg::wkevt_state_t state;
  logic [1:0] wake_cause_status;
  logic wake_pulse_select;
  logic wake_output_polarity;
  logic wake_output_enable;
  logic wake_active;
  logic [wkevt_pkg::CNT_W-1:0] pulse_cnt;
  logic [wkevt_pkg::CNT_W-1:0] settle_cnt;
  logic pmc_wr;
  logic energy_hit;
  logic frame_hit;
  logic any_hit;
  logic clear_energy;
  logic clear_frame;
  logic [1:0] next_cause;
  logic deactivate;
  logic pin_active;

  function automatic logic addr_is(input logic [7:0] a, input logic [7:0] o);
    return a == o;
  endfunction

  assign pmc_wr = host_req.wr && addr_is(host_req.addr, wkevt_pkg::PMC_OFFSET);
  // Interrupt path ignores wake_output_enable
  assign energy_hit = wake_src.energy_event && wake_src.energy_wake_en; // RQ19
  assign frame_hit = wake_src.frame_event && wake_src.frame_wake_en; // RQ19
  assign any_hit = energy_hit || frame_hit;

  // Clear needs full power, ready, and a quiet source
  assign clear_energy = pmc_wr && host_req.wdata[wkevt_pkg::ENERGY_CAUSE] &&
    ready && power_state_select == wkevt_pkg::FULL_POWER_STATE && // RQ3
    !wake_src.energy_pending; // RQ4
  assign clear_frame = pmc_wr && host_req.wdata[wkevt_pkg::FRAME_CAUSE] &&
    ready && power_state_select == wkevt_pkg::FULL_POWER_STATE && // RQ3
    !wake_src.frame_pending; // RQ4

  // Set wins over a clear in the same cycle
  always_comb begin
    next_cause = wake_cause_status;
    if (clear_energy) begin
      next_cause[0] = 1'b0; // RQ2
    end
    if (clear_frame) begin
      next_cause[1] = 1'b0; // RQ2
    end
    if (energy_hit) begin
      next_cause[0] = 1'b1; // RQ1
    end
    if (frame_hit) begin
      next_cause[1] = 1'b1; // RQ1
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      wake_cause_status <= wkevt_pkg::CAUSE_RESET;
    end else begin
      wake_cause_status <= next_cause;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      wake_pulse_select <= wkevt_pkg::CTRL_RESET;
      wake_output_polarity <= wkevt_pkg::CTRL_RESET;
      wake_output_enable <= wkevt_pkg::CTRL_RESET;
    end else if (pmc_wr) begin
      wake_pulse_select <= host_req.wdata[wkevt_pkg::PULSE_BIT];
      wake_output_polarity <= host_req.wdata[wkevt_pkg::POL_BIT];
      wake_output_enable <= host_req.wdata[wkevt_pkg::OUT_EN_BIT];
    end
  end

  // Indicator: static or timed pulse
  assign deactivate = (wake_cause_status != wkevt_pkg::CAUSE_NONE &&
    next_cause == wkevt_pkg::CAUSE_NONE) || !wake_output_enable; // RQ7

  always_ff @(posedge clk) begin
    if (!resetn) begin
      wake_active <= 1'b0;
      pulse_cnt <= '0;
    end else if (any_hit) begin
      wake_active <= 1'b1; // RQ6
      pulse_cnt <= wake_pulse_select ?
        wkevt_pkg::CNT_W'(PULSE_LEN) : '0; // RQ5
    end else if (deactivate) begin
      wake_active <= 1'b0; // RQ7
      pulse_cnt <= '0;
    end else if (pulse_cnt != '0) begin
      pulse_cnt <= pulse_cnt - 1'b1;
      if (pulse_cnt == wkevt_pkg::CNT_W'(1)) begin
        wake_active <= 1'b0; // RQ5
      end
    end
  end

  assign pin_active = wake_active && wake_output_enable; // RQ10

  // Open-drain pulls low only while active
  always_ff @(posedge clk) begin
    if (!resetn) begin
      wake_event_output <= 1'b1;
      wake_event_oe <= 1'b0;
    end else if (!wake_output_buffer_type) begin
      wake_event_output <= 1'b0; // RQ9
      wake_event_oe <= pin_active; // RQ9
    end else begin
      wake_event_output <= wake_output_polarity ?
        pin_active : !pin_active; // RQ8
      wake_event_oe <= 1'b1;
    end
  end

  assign wake_interrupt = wake_cause_status != wkevt_pkg::CAUSE_NONE; // RQ11

  // Ready sequencing
  always_ff @(posedge clk) begin
    if (!resetn) begin
      state <= wkevt_pkg::WK_SETTLE;
      settle_cnt <= '0;
    end else begin
      unique case (state)
        wkevt_pkg::WK_SETTLE: begin
          if (power_state_select != wkevt_pkg::FULL_POWER_STATE) begin
            state <= wkevt_pkg::WK_ASLEEP;
            settle_cnt <= '0;
          end else if (settle_cnt == wkevt_pkg::CNT_W'(SETTLE_LEN - 1)) begin
            state <= wkevt_pkg::WK_READY; // RQ20
          end else begin
            settle_cnt <= settle_cnt + 1'b1;
          end
        end
        wkevt_pkg::WK_READY: begin
          // Reserved code is treated as a sleep state, never as awake
          if (power_state_select != wkevt_pkg::FULL_POWER_STATE) begin
            state <= wkevt_pkg::WK_ASLEEP; // RQ17 RQ20
          end
        end
        wkevt_pkg::WK_ASLEEP: begin
          if (power_state_select == wkevt_pkg::FULL_POWER_STATE) begin
            state <= wkevt_pkg::WK_SETTLE;
            settle_cnt <= '0;
          end
        end
      endcase
    end
  end

  assign ready = state == wkevt_pkg::WK_READY; // RQ12

  // Only wake on byte-test writes outside full power
  always_ff @(posedge clk) begin
    if (!resetn) begin
      wake_request <= 1'b0;
    end else begin
      wake_request <= host_req.wr &&
        addr_is(host_req.addr, wkevt_pkg::BYTE_TEST_OFFSET) &&
        power_state_select != wkevt_pkg::FULL_POWER_STATE; // RQ18
    end
  end

  assign host_access_ok = ready ||
    addr_is(host_req.addr, wkevt_pkg::PMC_OFFSET) ||
    addr_is(host_req.addr, wkevt_pkg::HWCFG_OFFSET); // RQ15 RQ16

  // Reads answered in any state; other addresses return zero
  always_ff @(posedge clk) begin
    if (!resetn) begin
      host_rdata <= '0;
    end else if (host_req.rd &&
      addr_is(host_req.addr, wkevt_pkg::PMC_OFFSET)) begin
      host_rdata <= '0;
      host_rdata[wkevt_pkg::CAUSE_HI:wkevt_pkg::CAUSE_LO] <=
        wake_cause_status; // RQ13
      host_rdata[wkevt_pkg::PULSE_BIT] <= wake_pulse_select;
      host_rdata[wkevt_pkg::POL_BIT] <= wake_output_polarity;
      host_rdata[wkevt_pkg::OUT_EN_BIT] <= wake_output_enable;
      host_rdata[wkevt_pkg::READY_BIT] <= ready; // RQ14
    end else begin
      host_rdata <= '0;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  a_cause_energy_set: assert property ( // RQ1
    energy_hit |=> wake_cause_status[0])
    else $error("energy event not recorded");
  a_cause_clear_w1c: assert property ( // RQ2
    clear_frame && !frame_hit |=> !wake_cause_status[1])
    else $error("frame cause not cleared");
  a_clear_needs_ready: assert property ( // RQ3
    !ready && !energy_hit && wake_cause_status[0] |=>
    wake_cause_status[0])
    else $error("cause cleared while unready");
  a_clear_needs_quiet: assert property ( // RQ4
    wake_src.frame_pending && wake_cause_status[1] |=>
    wake_cause_status[1])
    else $error("cause cleared with source pending");
  a_pulse_load_len: assert property ( // RQ5
    any_hit && wake_pulse_select |=>
    pulse_cnt == wkevt_pkg::CNT_W'(PULSE_LEN) && wake_active)
    else $error("pulse length not loaded");
  a_pulse_expire: assert property ( // RQ5
    wake_active && pulse_cnt == wkevt_pkg::CNT_W'(1) && !any_hit |=>
    !wake_active)
    else $error("pulse outlived its length");
  a_static_hold: assert property ( // RQ6
    wake_active && !wake_pulse_select && !deactivate |=>
    wake_active)
    else $error("static output dropped");
  a_enable_off_deact: assert property ( // RQ7
    !wake_output_enable && !any_hit |=> !wake_active)
    else $error("output not deactivated");
  a_polarity_level: assert property ( // RQ8
    wake_output_buffer_type && pin_active |=>
    wake_event_output == $past(wake_output_polarity))
    else $error("push-pull active level wrong");
  a_pin_gated: assert property ( // RQ10
    !wake_output_enable |=>
    (wake_output_buffer_type ? wake_event_output != wake_output_polarity
    : !wake_event_oe) || $changed(wake_output_buffer_type) ||
    $changed(wake_output_polarity))
    else $error("pin asserted while disabled");
  a_open_drain_low: assert property ( // RQ9
    !wake_output_buffer_type |=> !wake_event_output)
    else $error("open-drain drove high");
  a_open_drain_oe: assert property ( // RQ9
    !wake_output_buffer_type && pin_active |=> wake_event_oe)
    else $error("open-drain did not pull low");
  a_ready_drop: assert property ( // RQ20
    power_state_select != wkevt_pkg::FULL_POWER_STATE |=> !ready)
    else $error("ready held in low power");
  a_ready_settled: assert property ( // RQ20
    $rose(ready) |-> $past(state) == wkevt_pkg::WK_SETTLE &&
    $past(settle_cnt) == wkevt_pkg::CNT_W'(SETTLE_LEN - 1))
    else $error("ready rose before settling");
  a_settle_then_ready: assert property ( // RQ12
    state == wkevt_pkg::WK_ASLEEP &&
    power_state_select == wkevt_pkg::FULL_POWER_STATE |=> !ready[*2])
    else $error("ready without settling");
  a_irq_no_enable: assert property ( // RQ11
    any_hit |=> wake_interrupt)
    else $error("interrupt missing");
  a_read_answer: assert property ( // RQ13
    host_req.rd && addr_is(host_req.addr, wkevt_pkg::PMC_OFFSET) |=>
    host_rdata[wkevt_pkg::READY_BIT] == $past(ready) &&
    host_rdata[wkevt_pkg::CAUSE_HI:wkevt_pkg::CAUSE_LO] ==
    $past(wake_cause_status))
    else $error("control read not answered");
  a_cfg_access: assert property ( // RQ16
    addr_is(host_req.addr, wkevt_pkg::HWCFG_OFFSET) |-> host_access_ok)
    else $error("config access refused");
  a_access_block: assert property ( // RQ15
    !ready && !addr_is(host_req.addr, wkevt_pkg::PMC_OFFSET) &&
    !addr_is(host_req.addr, wkevt_pkg::HWCFG_OFFSET) |-> !host_access_ok)
    else $error("access allowed while unready");
  a_wake_on_test: assert property ( // RQ18
    host_req.wr && addr_is(host_req.addr, wkevt_pkg::BYTE_TEST_OFFSET) &&
    power_state_select != wkevt_pkg::FULL_POWER_STATE |=> wake_request)
    else $error("byte-test write did not wake");
  a_no_wake_awake: assert property ( // RQ18
    power_state_select == wkevt_pkg::FULL_POWER_STATE |=> !wake_request)
    else $error("wake request in full power");

  c_pulse_event: cover property (any_hit && wake_pulse_select);
  c_cause_cleared: cover property (clear_energy || clear_frame);
  c_wake_request: cover property (wake_request ##[1:100] ready);
  c_open_drain_drive: cover property (!wake_output_buffer_type && wake_event_oe);
  c_sleep_read: cover property (!ready && host_req.rd);
endmodule

//--- inc/wkevt_pkg.sv
package wkevt_pkg;
  // Register map, byte offsets on the host register port
  localparam logic [7:0] PMC_OFFSET = 8'h84;
  localparam logic [7:0] HWCFG_OFFSET = 8'h74;
  localparam logic [7:0] BYTE_TEST_OFFSET = 8'h64;

  // Field positions in power_mgmt_control
  localparam int READY_BIT = 0;
  localparam int OUT_EN_BIT = 1;
  localparam int POL_BIT = 2;
  localparam int PULSE_BIT = 3;
  localparam int CAUSE_LO = 4;
  localparam int CAUSE_HI = 5;
  localparam int ENERGY_CAUSE = 4;
  localparam int FRAME_CAUSE = 5;

  // Reset values
  localparam logic [1:0] CAUSE_RESET = 2'h0;
  localparam logic CTRL_RESET = 1'b0;

  // Cause encodings
  localparam logic [1:0] CAUSE_NONE = 2'h0;
  localparam logic [1:0] CAUSE_ENERGY = 2'h1;
  localparam logic [1:0] CAUSE_FRAME = 2'h2;
  localparam logic [1:0] CAUSE_MULTI = 2'h3;

  // Power state encodings
  localparam logic [1:0] FULL_POWER_STATE = 2'h0;
  localparam logic [1:0] FRAME_WAKE_STATE = 2'h1;
  localparam logic [1:0] ENERGY_WAKE_STATE = 2'h2;
  localparam logic [1:0] RESERVED_STATE = 2'h3;

  // Timing
  localparam int CLK_MHZ = 250;
  localparam int PULSE_MS = 50;
  localparam int PULSE_CYCLES = PULSE_MS * CLK_MHZ * 1000;
  localparam int SETTLE_US = 2;
  localparam int SETTLE_CYCLES = SETTLE_US * CLK_MHZ;
  localparam int CNT_W = 24;

  typedef struct packed {
    logic [7:0] addr;
    logic wr;
    logic rd;
    logic [31:0] wdata;
  } wkevt_req_t;

  typedef struct packed {
    logic energy_event;
    logic frame_event;
    logic energy_pending;
    logic frame_pending;
    logic energy_wake_en;
    logic frame_wake_en;
  } wkevt_src_t;

  typedef enum logic [1:0] {WK_SETTLE, WK_READY, WK_ASLEEP} wkevt_state_t;
endpackage

//--- test/tb.sv
`timescale 1ns/1ps
module tb;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  wkevt_pkg::wkevt_req_t host_req;
  logic [31:0] host_rdata;
  logic host_access_ok, wake_request, wake_interrupt, ready;
  logic wake_event_output, wake_event_oe;
  logic [1:0] power_state_select = 2'h0;
  wkevt_pkg::wkevt_src_t wake_src = 6'h03;
  logic wake_output_buffer_type = 1'b1;
  int fails = 0;
  int comparisons = 0;
  int cycles = 0;
  int wakes = 0;
  logic [31:0] d;
  logic ok;
  logic [7:0] cfg [3] = '{8'h04, 8'h02, 8'h06};
  logic bt [3] = '{1'b1, 1'b1, 1'b0};
  logic idle [3] = '{1'b0, 1'b1, 1'b0};
  localparam logic [7:0] PMC = wkevt_pkg::PMC_OFFSET;

  always #2 clk = ~clk;

  wkevt_ctrl #(.PULSE_LEN(20), .SETTLE_LEN(8)) wkevt_ctrl_inst (
    .clk, .resetn, .host_req, .host_rdata, .host_access_ok,
    .power_state_select, .wake_src, .wake_output_buffer_type,
    .wake_request, .wake_interrupt, .ready, .wake_event_output,
    .wake_event_oe);

  wkevt_host wkevt_host_inst (.clk, .host_req, .host_rdata,
    .host_access_ok);

  task automatic report_and_stop();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (wake_request === 1'b1)
      wakes <= wakes + 1;
    if (cycles == 5000) begin
      fails = fails + 1;
      report_and_stop();
    end
  end

  task automatic chk_word(input string n, input logic [31:0] e,
    input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      fails++;
      $display("mismatch %s exp %h got %h", n, e, g);
    end
  endtask

  task automatic chk_pin(input string n, input logic e, input logic g);
    chk_word(n, {31'h0, e}, {31'h0, g});
  endtask

  task automatic rd(input logic [7:0] a);
    wkevt_host_inst.go(a, 1'b0, 32'h0, d, ok);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    wkevt_host_inst.go(a, 1'b1, v, d, ok);
  endtask

  // One-cycle event, then wait until the pin has settled
  task automatic pulse(input logic fr);
    @(posedge clk);
    wake_src.frame_event <= fr;
    wake_src.energy_event <= !fr;
    @(posedge clk);
    wake_src.frame_event <= 1'b0;
    wake_src.energy_event <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
  endtask

  initial begin
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    rd(PMC);
    chk_word("ctrl_reset", 32'h0, d);
    rd(wkevt_pkg::HWCFG_OFFSET);
    chk_pin("cfg_access", 1'b1, ok);
    wkevt_host_inst.wait_ready(ok);
    chk_pin("ready_up", 1'b1, ok);
    chk_pin("ready_pin", 1'b1, ready);
    wr(PMC, 32'h06);
    pulse(1'b1);
    chk_pin("irq", 1'b1, wake_interrupt);
    chk_pin("pin_static", 1'b1, wake_event_output);
    @(posedge clk) wake_src.frame_pending <= 1'b1;
    wr(PMC, 32'h26);
    rd(PMC);
    chk_word("clear_pending", 32'h27, d);
    @(posedge clk) wake_src.frame_pending <= 1'b0;
    wr(PMC, 32'h16);
    rd(PMC);
    chk_word("write_zero", 32'h27, d);
    chk_pin("pin_held", 1'b1, wake_event_output);
    wr(PMC, 32'h26);
    rd(PMC);
    chk_word("cleared", 32'h07, d);
    chk_pin("pin_off", 1'b0, wake_event_output);
    wr(PMC, 32'h0e);
    pulse(1'b0);
    // Last high cycle, then first low cycle of the pulse
    repeat (18) @(posedge clk);
    #1;
    chk_pin("pulse_on", 1'b1, wake_event_output);
    @(posedge clk);
    #1;
    chk_pin("pulse_end", 1'b0, wake_event_output);
    pulse(1'b1);
    rd(PMC);
    chk_word("multi", 32'h3f, d);
    wr(PMC, 32'h3e);
    for (int i = 0; i < 3; i++) begin
      @(posedge clk) wake_output_buffer_type <= bt[i];
      wr(PMC, {24'h0, cfg[i]});
      pulse(1'b1);
      chk_pin("irq_cfg", 1'b1, wake_interrupt);
      chk_pin("oe_on", 1'b1, wake_event_oe);
      chk_pin("pin_on", 1'b0, wake_event_output);
      wr(PMC, {24'h0, cfg[i] | 8'h20});
      rd(PMC);
      chk_pin("oe_off", bt[i], wake_event_oe);
      if (bt[i])
        chk_pin("pin_idle", idle[i], wake_event_output);
    end
    @(posedge clk) wake_output_buffer_type <= 1'b1;
    for (int s = 1; s < 3; s++) begin
      @(posedge clk) power_state_select <= s[1:0];
      pulse(s == 1);
      rd(PMC);
      chk_word("asleep", s == 1 ? 32'h26 : 32'h16, d);
      wr(PMC, 32'h36);
      rd(PMC);
      chk_word("asleep_clr", s == 1 ? 32'h26 : 32'h16, d);
      wr(wkevt_pkg::BYTE_TEST_OFFSET, 32'h0);
      chk_pin("bt_unready", 1'b0, ok);
      @(posedge clk) power_state_select <= 2'h0;
      wkevt_host_inst.wait_ready(ok);
      chk_pin("rewake", 1'b1, ok);
      chk_word("wake_req", s, wakes);
      wr(PMC, 32'h36);
      rd(PMC);
      chk_word("awake_clr", 32'h07, d);
    end
    // Disabled source must not raise the interrupt
    @(posedge clk) wake_src.frame_wake_en <= 1'b0;
    pulse(1'b1);
    chk_pin("irq_gated", 1'b0, wake_interrupt);
    chk_pin("pin_gated", 1'b0, wake_event_output);
    report_and_stop();
  end
endmodule

//--- test/wkevt_host.sv
`timescale 1ns/1ps
module wkevt_host (
  // Clock
  input wire logic clk,
  // Register port
  output wkevt_pkg::wkevt_req_t host_req,
  input wire logic [31:0] host_rdata,
  input wire logic host_access_ok
);
  initial host_req = '{8'h9b, 1'b0, 1'b0, 32'h5a5a_a5a5};

  // One access; the released bus shows inverted values, not stale ones
  task automatic go(input logic [7:0] a, input logic w,
    input logic [31:0] wd, output logic [31:0] rd, output logic ok);
    @(posedge clk);
    host_req <= '{a, w, !w, wd};
    #1 ok = host_access_ok;
    @(posedge clk);
    host_req <= '{~a, 1'b0, 1'b0, ~wd};
    #1 rd = host_rdata;
  endtask

  // Polls only the control register until the device is up
  task automatic wait_ready(output logic up);
    logic [31:0] d;
    logic a;
    up = 1'b0;
    for (int i = 0; i < 40 && !up; i++) begin
      go(wkevt_pkg::PMC_OFFSET, 1'b0, 32'h0, d, a);
      up = (d[0] === 1'b1);
    end
  endtask
endmodule
